// >>> core/dpram_cfg.svh
`ifndef DPRAM_CFG_SVH
`define DPRAM_CFG_SVH

// width select codes, one per shape
`define WSEL_X1      2'h0
`define WSEL_X2      2'h1
`define WSEL_X4      2'h2
`define WSEL_X9      2'h3

// lane masks for each shape
`define MASK_X1      9'h001
`define MASK_X2      9'h003
`define MASK_X4      9'h00f
`define MASK_X9      9'h1ff

// register byte offsets
`define CTRL_OFS     4'h0
`define STATUS_OFS   4'h4

// control register fields and reset value
`define CTRL_PIPE_A  0
`define CTRL_PIPE_B  1
`define CTRL_PASS_A  2
`define CTRL_PASS_B  3
`define CTRL_W       4
`define CTRL_RESET   4'h0

`endif

// >>> core/dpram_pkg.sv
`include "dpram_cfg.svh"

package dpram_pkg;

   typedef logic [1:0]  width_sel_t;
   typedef logic [8:0]  ram_word_t;
   typedef logic [11:0] ram_addr_t;
   typedef logic [8:0]  word_index_t;
   typedef logic [3:0]  lane_shift_t;

   function automatic word_index_t word_index(input width_sel_t w, input ram_addr_t a);
      case (w)
         `WSEL_X1: word_index = a[11:3];
         `WSEL_X2: word_index = a[10:2];
         `WSEL_X4: word_index = a[9:1];
         default:  word_index = a[8:0];
      endcase
   endfunction : word_index

   function automatic lane_shift_t lane_shift(input width_sel_t w, input ram_addr_t a);
      case (w)
         `WSEL_X1: lane_shift = {1'b0, a[2:0]};
         `WSEL_X2: lane_shift = {1'b0, a[1:0], 1'b0};
         `WSEL_X4: lane_shift = {1'b0, a[0], 2'b00};
         default:  lane_shift = 4'h0;
      endcase
   endfunction : lane_shift

   function automatic ram_word_t base_mask(input width_sel_t w);
      case (w)
         `WSEL_X1: base_mask = `MASK_X1;
         `WSEL_X2: base_mask = `MASK_X2;
         `WSEL_X4: base_mask = `MASK_X4;
         default:  base_mask = `MASK_X9;
      endcase
   endfunction : base_mask

endpackage : dpram_pkg

// >>> core/ram_port_if.sv
`timescale 1ns/1ns

interface ram_port_if;
   import dpram_pkg::*;

   logic       op_edge;
   logic       op_en;
   logic       op_write;
   ram_addr_t  addr;
   ram_word_t  wdata;
   width_sel_t width;

   modport front (output op_edge, op_en, op_write, addr, wdata, width);
   modport core  (input  op_edge, op_en, op_write, addr, wdata, width);
endinterface : ram_port_if

// >>> core/port_front.sv
`timescale 1ns/1ns

// brings one user port into the clk_i domain and marks its rising clock edges
module port_front (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 ce_i,
   input  wire logic                 port_clk_i,
   input  wire logic                 en_n_i,
   input  wire logic                 write_i,
   input  wire dpram_pkg::ram_addr_t addr_i,
   input  wire dpram_pkg::ram_word_t wdata_i,
   input  wire dpram_pkg::width_sel_t width_i,
   ram_port_if.front                 bus
);
   import dpram_pkg::*;

   localparam int RAW_W = 26;

   logic [RAW_W-1:0] raw;
   logic [RAW_W-1:0] sync1;
   logic [RAW_W-1:0] sync2;
   logic             clk_prev;

   assign raw = {port_clk_i, en_n_i, write_i, addr_i, wdata_i, width_i};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1    <= '0;
         sync2    <= '0;
         clk_prev <= 1'b0;
      end else if (ce_i) begin
         sync1    <= raw;
         sync2    <= sync1;
         clk_prev <= sync2[RAW_W-1];
      end
   end

   // one pulse per rising edge of the port clock
   assign bus.op_edge  = sync2[RAW_W-1] & ~clk_prev;
   assign bus.op_en    = ~sync2[RAW_W-2];
   assign bus.op_write = sync2[RAW_W-3];
   assign bus.addr     = sync2[22:11];
   assign bus.wdata    = sync2[10:2];
   assign bus.width    = sync2[1:0];
endmodule : port_front

// >>> core/dual_port_ram_block.sv
// Overview of operation
// - the memory takes one of four shapes, 4096x1, 2048x2, 1024x4 or 512x9.
// - each port picks its own shape through its own width select, whatever the other port picks.
// - every read and write is taken on a rising edge of that port's clock.
// - the two ports run independently on their own clocks, which may differ in frequency.
// - the read path is either pipelined through an extra output register or not.
// - while a port's active-low enable is high that port neither reads nor writes.
// - each port has its own input choosing read or write for each clock edge.
// - an active-low reset acts asynchronously, without waiting for either port clock.
// - on a write the read output either shows the written data or holds its old value.
//
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`include "dpram_cfg.svh"

module dual_port_ram_block #(
   parameter int WORDS = 512
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  ce_i,
   input  wire logic                  ram_reset_n_i,
   input  wire logic [3:0]            wb_adr_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic [31:0]                wb_dat_o,
   input  wire logic                  wb_we_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   output logic                       wb_ack_o,
   input  wire logic                  port_a_clk_i,
   input  wire logic                  port_a_en_n_i,
   input  wire logic                  port_a_write_i,
   input  wire dpram_pkg::ram_addr_t  port_a_addr_i,
   input  wire dpram_pkg::ram_word_t  port_a_wdata_i,
   input  wire dpram_pkg::width_sel_t port_a_width_select_i,
   output dpram_pkg::ram_word_t       port_a_rdata_o,
   input  wire logic                  port_b_clk_i,
   input  wire logic                  port_b_en_n_i,
   input  wire logic                  port_b_write_i,
   input  wire dpram_pkg::ram_addr_t  port_b_addr_i,
   input  wire dpram_pkg::ram_word_t  port_b_wdata_i,
   input  wire dpram_pkg::width_sel_t port_b_width_select_i,
   output dpram_pkg::ram_word_t       port_b_rdata_o
);
   import dpram_pkg::*;

   logic [`CTRL_W-1:0] ctrl;
   logic               wb_req;
   logic               ctrl_wr;

   logic        [1:0] pin_clk;
   logic        [1:0] pin_en_n;
   logic        [1:0] pin_write;
   ram_addr_t         pin_addr  [2];
   ram_word_t         pin_wdata [2];
   width_sel_t        pin_width [2];

   logic        [1:0] pipe_sel;
   logic        [1:0] pass_sel;
   logic        [1:0] do_wr;
   logic        [1:0] do_rd;
   word_index_t       widx      [2];
   ram_word_t         wmask     [2];
   ram_word_t         wdat_al   [2];
   ram_word_t         rd_lane   [2];
   ram_word_t         stage1    [2];
   ram_word_t         stage2    [2];
   ram_word_t         rdata     [2];
   logic        [7:0] rd_cnt    [2];
   logic        [7:0] wr_cnt    [2];

   ram_word_t         mem       [WORDS];
   ram_word_t         next_mem  [WORDS];

   ram_port_if pif [2] ();

   assign pin_clk      = {port_b_clk_i, port_a_clk_i};
   assign pin_en_n     = {port_b_en_n_i, port_a_en_n_i};
   assign pin_write    = {port_b_write_i, port_a_write_i};
   assign pin_addr[0]  = port_a_addr_i;
   assign pin_addr[1]  = port_b_addr_i;
   assign pin_wdata[0] = port_a_wdata_i;
   assign pin_wdata[1] = port_b_wdata_i;
   assign pin_width[0] = port_a_width_select_i;
   assign pin_width[1] = port_b_width_select_i;

   assign pipe_sel = {ctrl[`CTRL_PIPE_B], ctrl[`CTRL_PIPE_A]};
   assign pass_sel = {ctrl[`CTRL_PASS_B], ctrl[`CTRL_PASS_A]};

   // reset bridge for the output stages: the pin clears them at once,
   // release waits two clk_i edges so it lands in step with clk_i
   logic [1:0] clr_sync;
   logic       stage_rst_n;

   always_ff @(posedge clk_i or negedge ram_reset_n_i) begin
      if (!ram_reset_n_i) begin
         clr_sync <= '0;
      end else if (ce_i) begin
         clr_sync <= {clr_sync[0], 1'b1};
      end
   end

   assign stage_rst_n = clr_sync[1];

   // per-port front end, lane decode and read output stages
   for (genvar p = 0; p < 2; p++) begin : g_port
      port_front u_front (
         .clk_i      (clk_i),
         .rst_i      (rst_i),
         .ce_i       (ce_i),
         .port_clk_i (pin_clk[p]),
         .en_n_i     (pin_en_n[p]),
         .write_i    (pin_write[p]),
         .addr_i     (pin_addr[p]),
         .wdata_i    (pin_wdata[p]),
         .width_i    (pin_width[p]),
         .bus        (pif[p])
      );

      logic        edge_p;
      lane_shift_t sh;
      ram_word_t   base;

      assign edge_p     = pif[p].op_edge;
      assign do_wr[p]   = edge_p & pif[p].op_en & pif[p].op_write;
      assign do_rd[p]   = edge_p & pif[p].op_en & ~pif[p].op_write;
      // shape decode: word index and lane within the 9-bit word
      assign widx[p]    = word_index(pif[p].width, pif[p].addr);
      assign sh         = lane_shift(pif[p].width, pif[p].addr);
      assign base       = base_mask(pif[p].width);
      assign wmask[p]   = base << sh;
      assign wdat_al[p] = (pif[p].wdata & base) << sh;
      assign rd_lane[p] = (mem[widx[p]] >> sh) & base;

      // output stages clear at once on the async reset
      always_ff @(posedge clk_i or negedge stage_rst_n) begin
         if (!stage_rst_n) begin
            stage1[p] <= '0;
            stage2[p] <= '0;
         end else if (rst_i) begin
            stage1[p] <= '0;
            stage2[p] <= '0;
         end else if (ce_i && edge_p) begin
            if (do_rd[p]) begin
               stage1[p] <= rd_lane[p];
            end else if (do_wr[p] && pass_sel[p]) begin
               stage1[p] <= pif[p].wdata & base;
            end
            stage2[p] <= stage1[p];
         end
      end

      assign rdata[p] = pipe_sel[p] ? stage2[p] : stage1[p];

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            rd_cnt[p] <= '0;
            wr_cnt[p] <= '0;
         end else if (ce_i) begin
            if (do_rd[p]) begin
               rd_cnt[p] <= rd_cnt[p] + 8'h01;
            end
            if (do_wr[p]) begin
               wr_cnt[p] <= wr_cnt[p] + 8'h01;
            end
         end
      end
   end

   assign port_a_rdata_o = rdata[0];
   assign port_b_rdata_o = rdata[1];

   // storage: port b lands after port a, so b wins on shared bits
   for (genvar w = 0; w < WORDS; w++) begin : g_word
      ram_word_t ma;
      ram_word_t mb;

      assign ma = (do_wr[0] && widx[0] == 9'(w)) ? wmask[0] : '0;
      assign mb = (do_wr[1] && widx[1] == 9'(w)) ? wmask[1] : '0;
      assign next_mem[w] = (((mem[w] & ~ma) | (wdat_al[0] & ma)) & ~mb)
                           | (wdat_al[1] & mb);

      always_ff @(posedge clk_i) begin
         if (ce_i) begin
            mem[w] <= next_mem[w];
         end
      end
   end

   // wishbone slave, one wait state
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // control register lives in byte lane 0 only
   assign ctrl_wr = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `CTRL_OFS);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else if (ce_i) begin
         wb_ack_o <= wb_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= `CTRL_RESET;
      end else if (ce_i && ctrl_wr) begin
         ctrl <= wb_dat_i[`CTRL_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (ce_i && wb_req) begin
         case (wb_adr_i)
            `CTRL_OFS:   wb_dat_o <= {28'h0, ctrl};
            `STATUS_OFS: wb_dat_o <= {wr_cnt[1], rd_cnt[1], wr_cnt[0], rd_cnt[0]};
            default:     wb_dat_o <= '0;
         endcase
      end
   end
endmodule : dual_port_ram_block

// >>> sim/dpram_props.sv
`timescale 1ns/1ns
module dpram_props #(
   parameter int WORDS = 512
) (
   input wire logic                 clk_i, rst_i, ce_i, ram_reset_n_i,
   input wire logic                 wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o,
   input wire logic [3:0]           wb_adr_i,
   input wire logic [31:0]          wb_dat_o,
   input wire logic                 port_a_clk_i, port_b_clk_i,
   input wire dpram_pkg::ram_word_t port_a_rdata_o, port_b_rdata_o
);
   import dpram_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // cycles since each port pin was seen rising, saturating
   logic [2:0] age_a, age_b;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         age_a <= 3'h7;
         age_b <= 3'h7;
      end else begin
         age_a <= $rose(port_a_clk_i) ? 3'h0 : age_a + {2'h0, age_a != 3'h7};
         age_b <= $rose(port_b_clk_i) ? 3'h0 : age_b + {2'h0, age_b != 3'h7};
      end
   end
   sequence take_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence
   // no bus write landing and no async clear around this edge
   sequence quiet_s;
      !wb_ack_o && ram_reset_n_i && $past(ram_reset_n_i);
   endsequence
   ack_after_take_a: assert property (take_s |=> wb_ack_o)
      else $error("ack missing after request");
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_has_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   unmapped_zero_a: assert property (take_s ##0 (!wb_we_i && wb_adr_i != 4'h0
      && wb_adr_i != 4'h4) |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   ctrl_upper_a: assert property (take_s ##0 (!wb_we_i && wb_adr_i == 4'h0)
      |=> wb_dat_o[31:4] == 28'h0)
      else $error("control upper bits not zero");
   areset_clear_a: assert property (!ram_reset_n_i |-> port_a_rdata_o == 9'h0
      && port_b_rdata_o == 9'h0)
      else $error("read data not cleared");
   hold_port_a_a: assert property (quiet_s ##0 $changed(port_a_rdata_o)
      |-> age_a inside {[3'h1:3'h6]})
      else $error("port a data moved without port edge");
   hold_port_b_a: assert property (quiet_s ##0 $changed(port_b_rdata_o)
      |-> age_b inside {[3'h1:3'h6]})
      else $error("port b data moved without port edge");
   frozen_bus_a: assert property (!ce_i |=> $stable(wb_ack_o) && $stable(wb_dat_o))
      else $error("bus outputs moved while clock enable low");
endmodule : dpram_props
bind dual_port_ram_block dpram_props #(.WORDS(WORDS)) i_dpram_props (.*);

// >>> sim/port_user.sv
`timescale 1ns/1ns
module port_user #(
   parameter int HALF = 3
) (
   input  wire logic           clk_i,
   output logic                pclk_o,
   output logic                en_n_o,
   output logic                write_o,
   output dpram_pkg::ram_addr_t  addr_o,
   output dpram_pkg::ram_word_t  wdata_o,
   output dpram_pkg::width_sel_t width_o
);
   import dpram_pkg::*;
   int rd_cnt = 0;
   int wr_cnt = 0;
   initial begin
      {pclk_o, en_n_o, write_o} = 3'b010;
      {addr_o, wdata_o, width_o} = '0;
   end
   // one port clock pulse; controls stand HALF cycles around each edge
   task automatic op(input logic en_n, input logic wr, input ram_addr_t a,
                     input ram_word_t d, input width_sel_t w);
      @(posedge clk_i);
      {en_n_o, write_o, addr_o, wdata_o, width_o} <= {en_n, wr, a, d, w};
      repeat (HALF) @(posedge clk_i);
      pclk_o <= 1'b1;
      repeat (HALF) @(posedge clk_i);
      pclk_o <= 1'b0;
      repeat (HALF) @(posedge clk_i);
      wdata_o <= ~d;
      if (!en_n && wr) wr_cnt++;
      if (!en_n && !wr) rd_cnt++;
   endtask : op
endmodule : port_user

// >>> sim/tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
   $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
   import dpram_pkg::*;
   logic clk_i, rst_i, rn, ce, cyc, we, ack;
   logic [3:0] adr, sel;
   logic [31:0] dat, dat_o, rd;
   logic ac, ae, aw, bc, be, bw;
   ram_addr_t aa, ba;
   ram_word_t ad, bd, ra, rb;
   width_sel_t as, bs;
   int fails = 0, checks_done = 0, cycles = 0;
   port_user #(.HALF(3)) i_a (.clk_i, .pclk_o(ac), .en_n_o(ae), .write_o(aw),
      .addr_o(aa), .wdata_o(ad), .width_o(as));
   port_user #(.HALF(4)) i_b (.clk_i, .pclk_o(bc), .en_n_o(be), .write_o(bw),
      .addr_o(ba), .wdata_o(bd), .width_o(bs));
   dual_port_ram_block i_dual_port_ram_block (.clk_i, .rst_i, .ce_i(ce),
      .ram_reset_n_i(rn), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack),
      .port_a_clk_i(ac), .port_a_en_n_i(ae), .port_a_write_i(aw), .port_a_addr_i(aa),
      .port_a_wdata_i(ad), .port_a_width_select_i(as), .port_a_rdata_o(ra),
      .port_b_clk_i(bc), .port_b_en_n_i(be), .port_b_write_i(bw), .port_b_addr_i(ba),
      .port_b_wdata_i(bd), .port_b_width_select_i(bs), .port_b_rdata_o(rb));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         end_sim();
      end
   end
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      @(posedge clk_i);
      {cyc, we, adr, dat, sel} <= {1'b1, w, a, d, s};
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = dat_o;
      {cyc, we} <= 2'b00;
      dat <= ~d;
      @(posedge clk_i);
   endtask : wb
   task automatic sc_shapes();
      ram_addr_t ta[4] = '{12'h02a, 12'h015, 12'h00b, 12'h005};
      ram_word_t te[4] = '{9'h001, 9'h001, 9'h00a, 9'h1a5};
      i_a.op(0, 1, 12'h005, 9'h1a5, 2'h3);
      for (int k = 0; k < 4; k++) begin
         i_b.op(0, 0, ta[k], 9'h0, width_sel_t'(k));
         `CHK(rb, te[k])
      end
      i_a.op(0, 1, 12'h029, 9'h001, 2'h0);
      i_a.op(1, 1, 12'h005, 9'h000, 2'h3);
      i_b.op(0, 0, 12'h005, 9'h0, 2'h3);
      `CHK(rb, 9'h1a7)
   endtask : sc_shapes
   task automatic sc_options();
      wb(1, 4'h0, 32'h4, 4'hf);
      i_a.op(0, 1, 12'h007, 9'h0c3, 2'h3);
      `CHK(ra, 9'h0c3)
      wb(1, 4'h0, 32'h2, 4'hf);
      i_a.op(0, 1, 12'h007, 9'h111, 2'h3);
      `CHK(ra, 9'h0c3)
      i_b.op(0, 0, 12'h007, 9'h0, 2'h3);
      `CHK(rb, 9'h1a7)
      i_b.op(1, 0, 12'h005, 9'h0, 2'h3);
      `CHK(rb, 9'h111)
      wb(1, 4'h0, 32'hf, 4'he);
      wb(0, 4'h0, 32'h0, 4'hf);
      `CHK(rd, 32'h2)
   endtask : sc_options
   task automatic sc_bus();
      wb(1, 4'h0, 32'h0, 4'hf);
      fork
         i_a.op(0, 1, 12'h009, 9'h055, 2'h3);
         i_b.op(0, 0, 12'h005, 9'h0, 2'h3);
      join
      `CHK(rb, 9'h1a7)
      i_a.op(0, 0, 12'h009, 9'h0, 2'h3);
      `CHK(ra, 9'h055)
      wb(1, 4'h8, 32'hf, 4'hf);
      wb(1, 4'h4, 32'hf, 4'hf);
      wb(0, 4'h8, 32'h0, 4'hf);
      `CHK(rd, 32'h0)
      wb(0, 4'h4, 32'h0, 4'hf);
      `CHK(rd, {i_b.wr_cnt[7:0], i_b.rd_cnt[7:0], i_a.wr_cnt[7:0], i_a.rd_cnt[7:0]})
      rn <= 1'b0;
      @(negedge clk_i);
      `CHK({ra, rb}, 18'h0)
      repeat (2) @(posedge clk_i);
      `CHK({ra, rb}, 18'h0)
      rn <= 1'b1;
   endtask : sc_bus
   task automatic sc_modes();
      wb(1, 4'h0, 32'h9, 4'h1);
      i_b.op(0, 1, 12'h00c, 9'h0f0, 2'h3);
      `CHK(rb, 9'h0f0)
      i_a.op(0, 0, 12'h00c, 9'h0, 2'h3);
      `CHK(ra, 9'h000)
      i_a.op(1, 0, 12'h00c, 9'h0, 2'h3);
      `CHK(ra, 9'h0f0)
   endtask : sc_modes
   task automatic sc_hold();
      @(posedge clk_i);
      ce <= 1'b0;
      fork
         wb(0, 4'h0, 32'h0, 4'hf);
         begin
            repeat (6) @(posedge clk_i);
            `CHK(ack, 1'b0)
            ce <= 1'b1;
         end
      join
      `CHK(rd, 32'h9)
   endtask : sc_hold
   task automatic sc_restricted();
      wb(1, 4'h0, 32'h0, 4'h1);
      // single-port use: port b parked with its width select at zero
      i_b.op(1, 0, 12'h000, 9'h0, 2'h0);
      i_a.op(0, 1, 12'h0e0, 9'h04b, 2'h3);
      i_a.op(0, 0, 12'h0e0, 9'h0, 2'h3);
      `CHK(ra, 9'h04b)
      // both port clocks from one source, port b high while port a is low
      fork
         i_a.op(0, 1, 12'h0e1, 9'h0b4, 2'h3);
         begin
            repeat (2) @(posedge clk_i);
            i_b.op(0, 0, 12'h0e0, 9'h0, 2'h3);
         end
      join
      `CHK(rb, 9'h04b)
      `CHK(ra, 9'h04b)
   endtask : sc_restricted
   initial begin
      {rst_i, rn, ce, cyc, we, adr, dat, sel} = {4'b1110, 41'h0};
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      `CHK({ra, rb}, 18'h0)
      sc_shapes();
      sc_options();
      sc_bus();
      sc_modes();
      sc_hold();
      sc_restricted();
      end_sim();
   end
endmodule : tb
